// ### design/rtcsr_map.svh
// Constants for the RTC serial register access target
`ifndef RTCSR_MAP_SVH
`define RTCSR_MAP_SVH
`define RTCSR_TARGET_ADDR 7'h68
`define RTCSR_PTR_RST     3'h0
`define RTCSR_PTR_STEP    3'h1
`define RTCSR_BIT_RST     4'h0
`define RTCSR_BIT_STEP    4'h1
`define RTCSR_BIT_LAST    4'h7
`define RTCSR_BITS        4'h8
`define RTCSR_BYTE_RST    8'h00
`define RTCSR_NUM_LOC     8
`endif

// ### design/rtcsr_pkg.sv
// Types shared by the RTC serial register access target
package rtcsr_pkg;
    // Link side bus phases
    typedef enum logic [3:0] {
        RTCSR_IDLE     = 4'h0,
        RTCSR_ADDR     = 4'h1,
        RTCSR_ADDR_ACK = 4'h2,
        RTCSR_PTR      = 4'h3,
        RTCSR_PTR_ACK  = 4'h4,
        RTCSR_WDATA    = 4'h5,
        RTCSR_WD_ACK   = 4'h6,
        RTCSR_RDATA    = 4'h7,
        RTCSR_RD_ACK   = 4'h8,
        RTCSR_SKIP     = 4'h9
    } rtcsr_state_t;

    // Request passed from link domain to the location store
    typedef struct packed {
        logic       wr;
        logic [2:0] idx;
        logic [7:0] data;
    } rtcsr_req_t;

    // Local write port of the calendar logic
    typedef struct packed {
        logic       we;
        logic [2:0] idx;
        logic [7:0] data;
    } rtcsr_usr_t;
endpackage : rtcsr_pkg

// ### design/rtcsr_target.sv
// Two-wire serial target giving byte access to eight RTC locations
// Overview of operation
// - Addressed for read, target sends byte at the current pointer.
// - Pointer advances only on controller acknowledge; next byte follows.
// - Sequential read runs through locations until the controller does not acknowledge.
// - Read without pointer write starts at the last stored pointer.
// - Write: first byte loads pointer, later bytes stored, pointer advances.
// - Target acknowledges address, pointer and data bytes in ninth clock.
// - Supply below switchover_threshold: deselect, ignore bus, block bus writes; calendar logic writes still land.
// - Only the fixed seven-bit target address with direction bit matches.
// - Eight locations seconds through control, reachable via the pointer.
// - Supply drop aborts any transfer and clears the pointer to zero.
// - On controller no-acknowledge the target releases the data line.
`timescale 1ns/1ps
`include "rtcsr_map.svh"

module rtcsr_target #(
    parameter int NUM_LOC = `RTCSR_NUM_LOC
) (
    // System clock domain
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    // Link clock domain
    input  wire logic                 link_clk,
    // Serial pins
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    output      logic                 sda_o,
    output      logic                 sda_oe,
    // Supply monitor, high while below switchover_threshold
    input  wire logic                 supply_low,
    // Calendar logic side
    input  wire rtcsr_pkg::rtcsr_usr_t usr_wr,
    output      logic [8*NUM_LOC-1:0] loc_q,
    output      logic                 link_busy
);
    import rtcsr_pkg::*;

    // Refuse sizes the three-bit pointer cannot serve
    if (NUM_LOC != `RTCSR_NUM_LOC) begin : g_bad_size
        $error("rtcsr_target: NUM_LOC must be eight");
    end

    // Link domain
    logic         lrst_q1, lrst;
    logic         scl_q1, scl_s, scl_p;
    logic         sda_q1, sda_s, sda_p;
    logic         pf_q1, pf_s;
    logic         ack_q1, ack_s, ack_p;
    rtcsr_state_t state;
    logic [3:0]   cnt;
    logic [7:0]   shift;
    logic [2:0]   word_index;
    logic         rw;
    logic         got_ack;
    logic         req_tgl;
    rtcsr_req_t   req;
    logic [7:0]   fetch;
    logic         ack_tgl;
    logic [7:0]   rsp_data;
    logic         link_act;

    // Reset and pin synchronisers on the link clock
    always_ff @(posedge link_clk) begin
        lrst_q1 <= rst;
        lrst    <= lrst_q1;
        scl_q1  <= scl_i;
        scl_s   <= scl_q1;
        scl_p   <= scl_s;
        sda_q1  <= sda_i;
        sda_s   <= sda_q1;
        sda_p   <= sda_s;
        pf_q1   <= supply_low;
        pf_s    <= pf_q1;
    end

    // Answer toggle from the store, edge marks fresh fetch data
    always_ff @(posedge link_clk) begin
        ack_q1 <= ack_tgl;
        ack_s  <= ack_q1;
        ack_p  <= ack_s;
    end

    wire start_c  = scl_s & scl_p & sda_p & ~sda_s;
    wire stop_c   = scl_s & scl_p & ~sda_p & sda_s;
    wire scl_rise = scl_s & ~scl_p;
    wire scl_fall = ~scl_s & scl_p;

    // Capture fetched byte when the store answers
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            fetch <= `RTCSR_BYTE_RST;
        end else if (ack_s != ack_p) begin
            fetch <= rsp_data;
        end
    end

    // Bus protocol engine
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            state      <= RTCSR_IDLE;
            cnt        <= `RTCSR_BIT_RST;
            shift      <= `RTCSR_BYTE_RST;
            word_index <= `RTCSR_PTR_RST;
            rw         <= 1'b0;
            got_ack    <= 1'b0;
            sda_oe     <= 1'b0;
            req_tgl    <= 1'b0;
            req        <= '0;
        end else if (pf_s) begin
            state      <= RTCSR_IDLE;
            sda_oe     <= 1'b0;
            word_index <= `RTCSR_PTR_RST;
            cnt        <= `RTCSR_BIT_RST;
        end else if (start_c) begin
            state  <= RTCSR_ADDR;
            cnt    <= `RTCSR_BIT_RST;
            sda_oe <= 1'b0;
        end else if (stop_c) begin
            state  <= RTCSR_IDLE;
            sda_oe <= 1'b0;
        end else begin
            unique case (state)
                RTCSR_IDLE, RTCSR_SKIP: begin
                    sda_oe <= 1'b0;
                end
                RTCSR_ADDR, RTCSR_PTR, RTCSR_WDATA: begin
                    if (scl_rise) begin
                        shift <= {shift[6:0], sda_s};
                        cnt   <= cnt + `RTCSR_BIT_STEP;
                    end else if (scl_fall && cnt == `RTCSR_BITS) begin
                        cnt <= `RTCSR_BIT_RST;
                        if (state == RTCSR_ADDR) begin
                            if (shift[7:1] == `RTCSR_TARGET_ADDR) begin
                                state  <= RTCSR_ADDR_ACK;
                                sda_oe <= 1'b1;
                                rw     <= shift[0];
                                if (shift[0]) begin
                                    // Prefetch from the held pointer
                                    req     <= {1'b0, word_index,
                                                `RTCSR_BYTE_RST};
                                    req_tgl <= ~req_tgl;
                                end
                            end else begin
                                state <= RTCSR_SKIP;
                            end
                        end else if (state == RTCSR_PTR) begin
                            state      <= RTCSR_PTR_ACK;
                            sda_oe     <= 1'b1;
                            word_index <= shift[2:0];
                        end else begin
                            state   <= RTCSR_WD_ACK;
                            sda_oe  <= 1'b1;
                            req     <= {1'b1, word_index, shift};
                            req_tgl <= ~req_tgl;
                        end
                    end
                end
                RTCSR_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw) begin
                            state  <= RTCSR_RDATA;
                            shift  <= fetch;
                            sda_oe <= ~fetch[7];
                        end else begin
                            state  <= RTCSR_PTR;
                            sda_oe <= 1'b0;
                        end
                    end
                end
                RTCSR_PTR_ACK: begin
                    if (scl_fall) begin
                        state  <= RTCSR_WDATA;
                        sda_oe <= 1'b0;
                    end
                end
                RTCSR_WD_ACK: begin
                    if (scl_fall) begin
                        state      <= RTCSR_WDATA;
                        sda_oe     <= 1'b0;
                        word_index <= word_index + `RTCSR_PTR_STEP;
                    end
                end
                RTCSR_RDATA: begin
                    if (scl_fall) begin
                        if (cnt == `RTCSR_BIT_LAST) begin
                            state  <= RTCSR_RD_ACK;
                            sda_oe <= 1'b0;
                            cnt    <= `RTCSR_BIT_RST;
                        end else begin
                            shift  <= {shift[6:0], 1'b0};
                            sda_oe <= ~shift[6];
                            cnt    <= cnt + `RTCSR_BIT_STEP;
                        end
                    end
                end
                RTCSR_RD_ACK: begin
                    if (scl_rise) begin
                        got_ack <= ~sda_s;
                        if (!sda_s) begin
                            word_index <= word_index
                                        + `RTCSR_PTR_STEP;
                            req     <= {1'b0,
                                        word_index + `RTCSR_PTR_STEP,
                                        `RTCSR_BYTE_RST};
                            req_tgl <= ~req_tgl;
                        end
                    end else if (scl_fall) begin
                        if (got_ack) begin
                            state  <= RTCSR_RDATA;
                            shift  <= fetch;
                            sda_oe <= ~fetch[7];
                        end else begin
                            state  <= RTCSR_SKIP;
                            sda_oe <= 1'b0;
                        end
                    end
                end
                default: begin
                    state  <= RTCSR_IDLE;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // Open drain: only a low level is ever driven
    always_ff @(posedge link_clk) begin
        sda_o <= 1'b0;
    end

    // Engine activity registered so one clean bit crosses domains
    always_ff @(posedge link_clk) begin
        link_act <= (state != RTCSR_IDLE);
    end

    // System domain
    logic       req_q1, req_s, req_p;
    logic       pf_c1, pf_c;
    logic       bsy_q1;
    logic [7:0] loc [NUM_LOC];

    // Synchronise link request toggle and supply level
    always_ff @(posedge clk) begin
        if (ce) begin
            req_q1 <= req_tgl;
            req_s  <= req_q1;
            pf_c1  <= supply_low;
            pf_c   <= pf_c1;
            bsy_q1 <= link_act;
        end
    end

    wire req_new = (req_s != req_p);

    // Request edge detect and read answer
    always_ff @(posedge clk) begin
        if (rst) begin
            req_p    <= 1'b0;
            ack_tgl  <= 1'b0;
            rsp_data <= `RTCSR_BYTE_RST;
            link_busy <= 1'b0;
        end else if (ce) begin
            req_p     <= req_s;
            link_busy <= bsy_q1;
            if (req_new && !req.wr) begin
                rsp_data <= loc[req.idx];
                ack_tgl  <= ~ack_tgl;
            end
        end
    end

    // Location store, one register per entry
    for (genvar i = 0; i < NUM_LOC; i++) begin : g_loc
        wire link_hit = req_new && req.wr && !pf_c
                        && (req.idx == 3'(i));
        always_ff @(posedge clk) begin
            if (rst) begin
                loc[i] <= `RTCSR_BYTE_RST;
            end else if (ce) begin
                if (link_hit) begin
                    loc[i] <= req.data;
                end else if (usr_wr.we && usr_wr.idx == 3'(i)) begin
                    loc[i] <= usr_wr.data;
                end
            end
        end
        assign loc_q[8*i +: 8] = loc[i];
    end
endmodule : rtcsr_target

// ### testbench/rtc_serial_register_access_tb.sv
// Testbench for the serial register access target
`timescale 1ns/1ps
module rtc_serial_register_access_tb;
    import rtcsr_pkg::*;
    logic        clk, rst, ce, link_clk, supply_low, scl, sda_low;
    logic        sda_o, sda_oe, link_busy;
    wire logic   sda;
    rtcsr_usr_t  usr_wr;
    logic [63:0] loc_q;
    int          errors, total_checks;
    // Open-drain data line with pull-up
    assign sda = (sda_oe ? sda_o : 1'b1) & ~sda_low;
    rtcsr_target u_dut (.clk(clk), .rst(rst), .ce(ce), .link_clk(link_clk),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .supply_low(supply_low), .usr_wr(usr_wr), .loc_q(loc_q),
        .link_busy(link_busy));
    rtcsr_ctl_model u_ctl (.link_clk(link_clk), .sda(sda), .scl(scl),
        .sda_low(sda_low));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #3.7;
        forever #7.5 link_clk = ~link_clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out();
        if (errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out
    // Controller sends a byte; line is the expected ninth-clock level
    task automatic send(input logic [7:0] b, input logic line);
        logic [7:0] rx;
        logic       a;
        u_ctl.xfer(b, 1'b1, rx, a);
        check({7'h0, a}, {7'h0, line});
    endtask : send
    task automatic recv(input logic nack, input logic [7:0] exp);
        logic [7:0] rx;
        logic       a;
        u_ctl.xfer(8'hff, nack, rx, a);
        check(rx, exp);
    endtask : recv
    // Write pointer then two data bytes
    task automatic t_write(input logic [2:0] p, input logic [7:0] d0, d1);
        logic [2:0] n;
        n = p + 3'h1;
        u_ctl.start();
        send(8'hd0, 1'b0);
        send({5'h0, p}, 1'b0);
        send(d0, 1'b0);
        send(d1, 1'b0);
        u_ctl.stop();
        repeat (4) @(posedge clk);
        check(loc_q[8*p+:8], d0);
        check(loc_q[8*n+:8], d1);
    endtask : t_write
    // Reads from the stored pointer; nack does not advance it
    task automatic t_current_read();
        u_ctl.start();
        send(8'hd1, 1'b0);
        recv(1'b0, 8'h55);
        recv(1'b1, 8'h66);
        u_ctl.stop();
        u_ctl.start();
        send(8'hd1, 1'b0);
        recv(1'b1, 8'h66);
        u_ctl.stop();
    endtask : t_current_read
    task automatic t_pointer_read();
        u_ctl.start();
        send(8'hd0, 1'b0);
        send(8'h06, 1'b0);
        u_ctl.start();
        send(8'hd1, 1'b0);
        recv(1'b0, 8'h00);
        recv(1'b0, 8'ha7);
        recv(1'b0, 8'h11);
        recv(1'b1, 8'h55);
        check({7'h0, sda_oe}, 8'h00);
        u_ctl.stop();
    endtask : t_pointer_read
    task automatic t_wrong_addr();
        u_ctl.start();
        send(8'hd2, 1'b1);
        u_ctl.stop();
        u_ctl.start();
        send(8'h68, 1'b1);
        u_ctl.stop();
    endtask : t_wrong_addr
    task automatic t_user_write();
        @(posedge clk);
        ce <= 1'b0;
        usr_wr <= '{we: 1'b1, idx: 3'h3, data: 8'h3c};
        repeat (3) @(posedge clk);
        check(loc_q[31:24], 8'h00);
        ce <= 1'b1;
        @(posedge clk);
        usr_wr <= '0;
        repeat (2) @(posedge clk);
        check(loc_q[31:24], 8'h3c);
    endtask : t_user_write
    task automatic t_supply_drop();
        u_ctl.start();
        send(8'hd0, 1'b0);
        send(8'h04, 1'b0);
        @(posedge clk);
        supply_low <= 1'b1;
        send(8'h99, 1'b1);
        u_ctl.stop();
        check(loc_q[39:32], 8'h00);
        @(posedge clk);
        supply_low <= 1'b0;
        repeat (200) @(posedge clk);
        u_ctl.start();
        send(8'hd1, 1'b0);
        recv(1'b1, 8'h11);
        u_ctl.stop();
    endtask : t_supply_drop
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        close_out();
    end
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        supply_low = 1'b0;
        usr_wr = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (20) @(posedge clk);
        check(loc_q[7:0], 8'h00);
        t_write(3'h1, 8'h55, 8'h66);
        t_write(3'h7, 8'ha7, 8'h11);
        t_current_read();
        t_user_write();
        t_pointer_read();
        t_wrong_addr();
        t_supply_drop();
        close_out();
    end
endmodule : rtc_serial_register_access_tb

// ### testbench/rtcsr_ctl_model.sv
// Bus controller model driving the serial clock and data line
`timescale 1ns/1ps
module rtcsr_ctl_model (
    // Link timing and resolved data line
    input  wire logic link_clk,
    input  wire logic sda,
    // Controller drives
    output logic      scl,
    output logic      sda_low
);
    localparam int Q = 64;
    // Idle bus: both lines high
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // One quarter of a bit period
    task automatic q();
        repeat (Q) @(posedge link_clk);
    endtask : q
    // Start and repeated start from scl low or idle
    task automatic start();
        sda_low <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        sda_low <= 1'b1;
        q();
        scl <= 1'b0;
        q();
    endtask : start
    // Stop ends any transfer
    task automatic stop();
        sda_low <= 1'b1;
        q();
        scl <= 1'b1;
        q();
        sda_low <= 1'b0;
        q();
    endtask : stop
    // One bit: data set while scl low, line sampled mid high period
    task automatic bit_io(input logic b, output logic r);
        sda_low <= !b;
        q();
        scl <= 1'b1;
        q();
        r = sda;
        q();
        scl <= 1'b0;
        q();
    endtask : bit_io
    // Eight bits MSB first, then the ninth clock
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_in, ack);
    endtask : xfer
endmodule : rtcsr_ctl_model

// ### testbench/rtcsr_target_checker.sv
// Port-level checks for the serial register access target
`timescale 1ns/1ps
module rtcsr_target_checker #(
    parameter int NUM_LOC = 8
) (
    // System domain
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  ce,
    // Link domain and pins
    input wire logic                  link_clk,
    input wire logic                  scl_i,
    input wire logic                  sda_i,
    input wire logic                  sda_o,
    input wire logic                  sda_oe,
    input wire logic                  supply_low,
    // Calendar side
    input wire rtcsr_pkg::rtcsr_usr_t usr_wr,
    input wire logic [8*NUM_LOC-1:0]  loc_q,
    input wire logic                  link_busy
);
    import rtcsr_pkg::*;

    // Link side: data drive timing and release
    chk_oe_scl_low: assert property (@(posedge link_clk)
        disable iff (rst)
        ($changed(sda_oe) && !supply_low) |-> !scl_i)
        else $error("data drive moved while serial clock high");
    chk_drive_is_low: assert property (@(posedge link_clk)
        disable iff (rst)
        sda_oe |-> (!sda_o && !sda_i))
        else $error("driven data line not low");
    chk_supply_release: assert property (@(posedge link_clk)
        disable iff (rst)
        supply_low [*8] |-> !sda_oe)
        else $error("data line held while supply low");
    chk_start_quiet: assert property (@(posedge link_clk)
        disable iff (rst)
        (scl_i && $fell(sda_i)) |=> !sda_oe [*4])
        else $error("data line driven right after start");

    // System side: store and busy flag
    chk_supply_idle: assert property (@(posedge clk)
        disable iff (rst)
        supply_low [*8] |-> !link_busy)
        else $error("link engine busy while supply low");
    chk_supply_nowrite: assert property (@(posedge clk)
        disable iff (rst)
        (supply_low [*8] ##0
         (!$past(usr_wr.we) && !$past(usr_wr.we, 2)))
        |-> $stable(loc_q))
        else $error("location changed while supply low");
    chk_ce_freeze: assert property (@(posedge clk)
        disable iff (rst)
        !ce |=> $stable(loc_q))
        else $error("locations changed with enable low");
    chk_oe_busy: assert property (@(posedge clk)
        disable iff (rst)
        sda_oe [*8] |-> link_busy)
        else $error("drive without busy engine");
endmodule : rtcsr_target_checker

bind rtcsr_target rtcsr_target_checker #(.NUM_LOC(NUM_LOC)) u_chk (
    .clk(clk), .rst(rst), .ce(ce), .link_clk(link_clk), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .supply_low(supply_low),
    .usr_wr(usr_wr), .loc_q(loc_q), .link_busy(link_busy));
